// ===== design/gpioph_consts.svh
/*
 * Constants of the general-purpose port block: data-memory offsets,
 * register kinds, reset values and implemented-bit masks.
 * Assumes inclusion from the package and the top module only.
 */
`ifndef GPIOPH_CONSTS_SVH
`define GPIOPH_CONSTS_SVH

// ************************************************************
// Data-memory map
// ************************************************************
`define GPIOPH_BASE_ADDR 8'h20
`define GPIOPH_PORT_STRIDE 4
`define GPIOPH_NUM_PORTS 6
`define GPIOPH_PORT_F 3'h5
`define GPIOPH_PORT_A 3'h0
`define GPIOPH_KIND_DATA 2'h0
`define GPIOPH_KIND_DIR 2'h1
`define GPIOPH_KIND_PULL 2'h2
`define GPIOPH_KIND_WAKE 2'h3

// ************************************************************
// Reset values and masks
// ************************************************************
`define GPIOPH_DATA_RST 8'hff
`define GPIOPH_DIR_RST 8'hff
`define GPIOPH_PULL_RST 8'h00
`define GPIOPH_WAKE_RST 8'h00
`define GPIOPH_FULL_MASK 8'hff
`define GPIOPH_PF_MASK 8'h01
`define GPIOPH_PIN_BITS 41

`endif

// ===== design/gpioph_pkg.sv
/*
 * Types of the general-purpose port block: pin bundle, register kind
 * and address decode result.
 * Assumes the constants header sits beside it.
 */
`include "gpioph_consts.svh"

package gpioph_pkg;

   // ************************************************************
   // Pin bundle: ports A..E eight pins, port F one pin
   // ************************************************************
   typedef struct packed {
      logic pf;
      logic [7:0] pe;
      logic [7:0] pd;
      logic [7:0] pc;
      logic [7:0] pb;
      logic [7:0] pa;
   } gpioph_pins_t;

   typedef enum logic [1:0] {
      GPIOPH_DATA = 2'h0,
      GPIOPH_DIR = 2'h1,
      GPIOPH_PULL = 2'h2,
      GPIOPH_WAKE = 2'h3
   } gpioph_kind_t;

   typedef struct packed {
      logic hit;
      logic [2:0] port;
      gpioph_kind_t kind;
   } gpioph_dec_t;

endpackage

// ===== design/gpioph_top.sv
/*
 * General-purpose ports A..F with data latch, direction, pull-high
 * enable per pin and falling-edge wake-up on port A.
 * Assumes a data-memory port in the clock domain of SYS_CLK_IN, pins
 * already synchronous except for the wake path, and a pad ring that
 * resolves pin level, enable and pull-high.
 */
// Behaviour
// - Ports A-E eight pins, F one pin
// - All port registers sit in data memory
// - Input read samples pin, no latching
// - Output latch holds until rewritten
// - Pull-high applies only to input pins
// - Pull enable one enables, resets zero
// - Port F bits 7..1 read zero
// - Sleep falling edge on enabled A wakes
// - Per-pin wake enable, resets zero
// - Direction one input, zero push-pull output
// - Output pin read returns latch content
// - Data and direction reset to ones
`include "gpioph_consts.svh"

module gpioph_top #(
   parameter int ADDR_W = 8
) (
   // Clock and reset
   input wire logic SYS_CLK_IN,
   input wire logic RST_IN,
   // Data-memory access
   input wire logic [ADDR_W-1:0] MEM_ADDR_IN,
   input wire logic MEM_WR_IN,
   input wire logic [7:0] MEM_WDATA_IN,
   input wire logic MEM_RD_IN,
   output logic [7:0] MEM_RDATA_OUT,
   output logic MEM_HIT_OUT,
   // Pins
   input wire gpioph_pkg::gpioph_pins_t PIN_IN,
   output gpioph_pkg::gpioph_pins_t PIN_OUT,
   output gpioph_pkg::gpioph_pins_t PIN_OE_OUT,
   output gpioph_pkg::gpioph_pins_t PULL_UP_OUT,
   // Power-down
   input wire logic SLEEP_IN,
   output logic WAKE_REQ_OUT
);
   import gpioph_pkg::*;

   // ************************************************************
   // Elaboration check
   // ************************************************************
   if (ADDR_W < 8) begin : g_bad_addr
      $error("ADDR_W must be at least 8");
   end

   localparam int NP = `GPIOPH_NUM_PORTS;

   // ************************************************************
   // Decode and helpers
   // ************************************************************
   function automatic gpioph_dec_t dec_addr(input logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] off;
      gpioph_dec_t d;
      off = a - ADDR_W'(`GPIOPH_BASE_ADDR);
      d.port = off[4:2];
      d.kind = gpioph_kind_t'(off[1:0]);
      d.hit = (a >= ADDR_W'(`GPIOPH_BASE_ADDR)) &&
              (off < ADDR_W'(NP * `GPIOPH_PORT_STRIDE)) &&
              ((d.kind != GPIOPH_WAKE) || (d.port == `GPIOPH_PORT_A));
      return d;
   endfunction

   // Port F carries one pin; its upper bits are always written as zero
   function automatic logic [7:0] impl_mask(input int p);
      return (p == int'(`GPIOPH_PORT_F)) ? `GPIOPH_PF_MASK : `GPIOPH_FULL_MASK;
   endfunction

   // Port select shared by the write and read paths
   function automatic logic sel_port(input gpioph_dec_t d, input int p);
      return d.hit && (int'(d.port) == p);
   endfunction

   // Input bits show the pad, output bits the latch
   function automatic logic [7:0] pin_or_latch(input logic [7:0] pin, input logic [7:0] dir,
         input logic [7:0] latch);
      return (pin & dir) | (latch & ~dir);
   endfunction

   // Read value of one port register; wake enable only reaches port A
   function automatic logic [7:0] read_mux(input gpioph_kind_t k, input logic [7:0] pin,
         input logic [7:0] dir, input logic [7:0] latch, input logic [7:0] pull,
         input logic [7:0] wen);
      logic [7:0] v;
      case (k)
         GPIOPH_DATA: v = pin_or_latch(pin, dir, latch);
         GPIOPH_DIR: v = dir;
         GPIOPH_PULL: v = pull;
         default: v = wen;
      endcase
      return v;
   endfunction

   // ************************************************************
   // Further elaboration checks
   // ************************************************************
   // The pin bundle must fit the byte-wide port slices used below
   if ($bits(gpioph_pins_t) != `GPIOPH_PIN_BITS) begin : g_bad_pins
      $error("pin bundle width does not match the port map");
   end
   if (NP * 8 < `GPIOPH_PIN_BITS) begin : g_bad_ports
      $error("too few ports for the pin bundle");
   end
   // Reset values treat the last port as the one-pin port
   if (int'(`GPIOPH_PORT_F) != NP - 1) begin : g_bad_last
      $error("one-pin port must be the last port");
   end
   if (`GPIOPH_PORT_STRIDE != 4) begin : g_bad_stride
      $error("decode assumes four registers per port");
   end

   // ************************************************************
   // State
   // ************************************************************
   // Register file
   logic [7:0] data_ff [NP];
   logic [7:0] dir_ff [NP];
   logic [7:0] pull_ff [NP];
   logic [7:0] wake_en_ff;
   logic [7:0] nxt_data [NP];
   logic [7:0] nxt_dir [NP];
   logic [7:0] nxt_pull [NP];
   logic [7:0] nxt_wake_en;

   // Read path
   logic [7:0] rdata_ff;
   logic [7:0] nxt_rdata;
   logic hit_ff;
   logic nxt_hit;

   // Pad controls
   gpioph_pins_t drv_ff;
   gpioph_pins_t oe_ff;
   gpioph_pins_t pu_ff;
   gpioph_pins_t nxt_drv;
   gpioph_pins_t nxt_oe;
   gpioph_pins_t nxt_pu;
   logic [47:0] pin_vec;
   logic [47:0] drv_vec;
   logic [47:0] oe_vec;
   logic [47:0] pu_vec;

   // Wake path
   logic [7:0] pa_meta_ff;
   logic [7:0] pa_sync_ff;
   logic [7:0] pa_prev_ff;
   logic wake_ff;
   logic nxt_wake;
   logic [7:0] fall;

   // Decode
   gpioph_dec_t dec;

   // ************************************************************
   // Address decode
   // ************************************************************
   // One decode feeds every group so they never disagree on a hit
   always_comb begin
      dec = dec_addr(MEM_ADDR_IN);
   end

   // ************************************************************
   // Register file
   // ************************************************************
   // Port F upper bits are masked on write, so they never read back
   always_comb begin
      nxt_wake_en = wake_en_ff;
      for (int p = 0; p < NP; p++) begin
         nxt_data[p] = data_ff[p];
         nxt_dir[p] = dir_ff[p];
         nxt_pull[p] = pull_ff[p];
         // Latch only changes on a write to it
         if (MEM_WR_IN && sel_port(dec, p)) begin
            case (dec.kind)
               GPIOPH_DATA: nxt_data[p] = MEM_WDATA_IN & impl_mask(p);
               GPIOPH_DIR: nxt_dir[p] = MEM_WDATA_IN & impl_mask(p);
               GPIOPH_PULL: nxt_pull[p] = MEM_WDATA_IN & impl_mask(p);
               // The decode refuses the wake kind outside port A
               default: nxt_wake_en = MEM_WDATA_IN;
            endcase
         end
      end
   end

   always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         for (int p = 0; p < NP; p++) begin
            data_ff[p] <= (p == NP - 1) ? `GPIOPH_PF_MASK : `GPIOPH_DATA_RST;
            dir_ff[p] <= (p == NP - 1) ? `GPIOPH_PF_MASK : `GPIOPH_DIR_RST;
            pull_ff[p] <= `GPIOPH_PULL_RST;
         end
         wake_en_ff <= `GPIOPH_WAKE_RST;
      end else begin
         for (int p = 0; p < NP; p++) begin
            data_ff[p] <= nxt_data[p];
            dir_ff[p] <= nxt_dir[p];
            pull_ff[p] <= nxt_pull[p];
         end
         wake_en_ff <= nxt_wake_en;
      end
   end

   // ************************************************************
   // Read path
   // ************************************************************
   // Data is registered, so a read answers one cycle after its strobe
   always_comb begin
      nxt_rdata = rdata_ff;
      nxt_hit = MEM_RD_IN & dec.hit;
      // Unmapped reads answer zero with no hit
      if (MEM_RD_IN && !dec.hit) begin
         nxt_rdata = 8'h00;
      end
      for (int p = 0; p < NP; p++) begin
         // Input pins are sampled live at the read edge, never latched
         if (MEM_RD_IN && sel_port(dec, p)) begin
            nxt_rdata = read_mux(dec.kind, pin_vec[p*8 +: 8], dir_ff[p], data_ff[p],
               pull_ff[p], wake_en_ff) & impl_mask(p);
         end
      end
   end

   always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         rdata_ff <= 8'h00;
         hit_ff <= 1'b0;
      end else begin
         rdata_ff <= nxt_rdata;
         hit_ff <= nxt_hit;
      end
   end

   // ************************************************************
   // Pad controls
   // ************************************************************
   // Bundle widened to whole bytes so each port slices alike
   assign pin_vec = {7'h00, PIN_IN};

   // Pads follow the new register values, so they move at the write edge
   for (genvar g = 0; g < NP; g++) begin : g_pad
      assign drv_vec[g*8 +: 8] = nxt_data[g];
      assign oe_vec[g*8 +: 8] = ~nxt_dir[g] & impl_mask(g);
      assign pu_vec[g*8 +: 8] = nxt_pull[g] & nxt_dir[g];
   end

   // Pull-high is gated by direction, so it never meets an enabled drive
   always_comb begin
      nxt_drv = drv_vec[`GPIOPH_PIN_BITS-1:0];
      nxt_oe = oe_vec[`GPIOPH_PIN_BITS-1:0];
      nxt_pu = pu_vec[`GPIOPH_PIN_BITS-1:0];
   end

   always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         drv_ff <= '1;
         oe_ff <= '0;
         pu_ff <= '0;
      end else begin
         drv_ff <= nxt_drv;
         oe_ff <= nxt_oe;
         pu_ff <= nxt_pu;
      end
   end

   // ************************************************************
   // Wake path
   // ************************************************************
   // Two flops settle the pad first; this costs three cycles of latency
   always_comb begin
      // Edge seen on the settled sample only
      fall = pa_prev_ff & ~pa_sync_ff & wake_en_ff;
      // Request holds until sleep ends; an edge in the cycle sleep ends does not set it
      nxt_wake = SLEEP_IN & (wake_ff | (|fall));
   end

   always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         // Idle pins sit high, so the compare starts from ones
         pa_meta_ff <= 8'hff;
         pa_sync_ff <= 8'hff;
         pa_prev_ff <= 8'hff;
         wake_ff <= 1'b0;
      end else begin
         pa_meta_ff <= PIN_IN.pa;
         pa_sync_ff <= pa_meta_ff;
         pa_prev_ff <= pa_sync_ff;
         wake_ff <= nxt_wake;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   // Every output is a flop, so the pads never see decode glitches
   assign MEM_RDATA_OUT = rdata_ff;
   assign MEM_HIT_OUT = hit_ff;
   assign PIN_OUT = drv_ff;
   assign PIN_OE_OUT = oe_ff;
   assign PULL_UP_OUT = pu_ff;
   assign WAKE_REQ_OUT = wake_ff;

endmodule

// ===== tb/gpioph_monitor.sv
/* Checker on the port block's top-level ports.
   Assumes a bind from the bench top and the block's address map. */
module gpioph_monitor #(
   parameter int ADDR_W = 8
) (
   // Clock, reset and memory side
   input wire logic SYS_CLK_IN,
   input wire logic RST_IN,
   input wire logic [ADDR_W-1:0] MEM_ADDR_IN,
   input wire logic MEM_WR_IN,
   input wire logic [7:0] MEM_WDATA_IN,
   input wire logic MEM_RD_IN,
   input wire logic [7:0] MEM_RDATA_OUT,
   input wire logic MEM_HIT_OUT,
   // Pins and power-down
   input wire gpioph_pkg::gpioph_pins_t PIN_IN,
   input wire gpioph_pkg::gpioph_pins_t PIN_OUT,
   input wire gpioph_pkg::gpioph_pins_t PIN_OE_OUT,
   input wire gpioph_pkg::gpioph_pins_t PULL_UP_OUT,
   input wire logic SLEEP_IN,
   input wire logic WAKE_REQ_OUT
);
   import gpioph_pkg::*;
   // ********
   // Wake enable shadow, the register itself is not visible here
   // ********
   logic [7:0] a;
   logic [7:0] wen_ff;
   logic [7:0] nxt_wen;
   assign a = MEM_ADDR_IN[7:0];
   always_comb nxt_wen = (MEM_WR_IN && a == 8'h23) ? MEM_WDATA_IN : wen_ff;
   always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
      if (RST_IN)
         wen_ff <= 8'h00;
      else
         wen_ff <= nxt_wen;
   end
   default clocking @(posedge SYS_CLK_IN);
   endclocking
   default disable iff (RST_IN);
   sequence fall_s;
      SLEEP_IN && |(wen_ff & $past(PIN_IN.pa) & ~PIN_IN.pa);
   endsequence
   sequence held_s;
      (SLEEP_IN && $stable(PIN_IN.pa))[*3];
   endsequence
   a_pull_input_only: assert property ((PULL_UP_OUT & PIN_OE_OUT) == '0)
      else $error("pull on driven pin");
   a_pf_upper_zero: assert property (MEM_RD_IN && a >= 8'h34 && a <= 8'h36
      |=> MEM_RDATA_OUT[7:1] == 7'h00) else $error("port f upper bits set");
   a_unmapped_read: assert property (MEM_RD_IN && a[1:0] == 2'h3 && a != 8'h23
      |=> !MEM_HIT_OUT && MEM_RDATA_OUT == 8'h00) else $error("unmapped read answered");
   a_latch_drives_pin: assert property (MEM_WR_IN && a == 8'h20
      |=> ##1 PIN_OUT.pa == $past(MEM_WDATA_IN, 2)) else $error("latch not on pad");
   a_dir_sets_enable: assert property (MEM_WR_IN && a == 8'h21
      |=> ##1 PIN_OE_OUT.pa == ~$past(MEM_WDATA_IN, 2)) else $error("enable wrong");
   a_latch_holds: assert property (!$stable(PIN_OUT) |-> $past(MEM_WR_IN))
      else $error("pad moved without write");
   a_wake_on_fall: assert property (fall_s ##1 held_s |-> ##[0:2] WAKE_REQ_OUT)
      else $error("no wake after fall");
   a_wake_cleared: assert property (!SLEEP_IN |=> !WAKE_REQ_OUT)
      else $error("wake while awake");
endmodule

// ===== tb/gpioph_board.sv
/* Board circuitry on the port pins: resolves each pad level.
   Assumes bench drivers stand back wherever the block drives. */
module gpioph_board (
   // Clock
   input wire logic clk_in,
   // Block and bench drives
   input wire gpioph_pkg::gpioph_pins_t drv_in,
   input wire gpioph_pkg::gpioph_pins_t oe_in,
   input wire gpioph_pkg::gpioph_pins_t pull_in,
   input wire gpioph_pkg::gpioph_pins_t ext_en_in,
   input wire gpioph_pkg::gpioph_pins_t ext_val_in,
   output gpioph_pkg::gpioph_pins_t level_out
);
   import gpioph_pkg::*;
   gpioph_pins_t last_ff = '0;
   always @(posedge clk_in)
      last_ff <= level_out;
   // A floating pad toggles, so a stale level never passes for a read
   assign level_out = (oe_in & drv_in) | (~oe_in & ext_en_in & ext_val_in)
      | (~oe_in & ~ext_en_in & pull_in)
      | (~oe_in & ~ext_en_in & ~pull_in & ~last_ff);
endmodule

// ===== tb/gpio_ports_pullup_wakeup_tb.sv
/* Self-checking bench for the port block with a board model on the pins.
   Assumes port p at 0x20+4p: data, direction, pull, wake at 0x23. */
module gpio_ports_pullup_wakeup_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import gpioph_pkg::*;
   logic clk = 0, rst = 1, wr = 0, rd = 0, slp = 0, hit, wake;
   logic [7:0] addr = '0, wdat = '0, rdat;
   gpioph_pins_t pin, pout, poe, pull, ext_en = '1, ext_val = 41'h1_5a_3c_96_c3_a5;
   int miscompares = 0, check_count = 0, cyc = 0;
   always #5 clk = ~clk;
   gpioph_top i_dut (.SYS_CLK_IN(clk), .RST_IN(rst), .MEM_ADDR_IN(addr), .MEM_WR_IN(wr),
      .MEM_WDATA_IN(wdat), .MEM_RD_IN(rd), .MEM_RDATA_OUT(rdat), .MEM_HIT_OUT(hit),
      .PIN_IN(pin), .PIN_OUT(pout), .PIN_OE_OUT(poe), .PULL_UP_OUT(pull),
      .SLEEP_IN(slp), .WAKE_REQ_OUT(wake));
   gpioph_board i_board (.clk_in(clk), .drv_in(pout), .oe_in(poe), .pull_in(pull),
      .ext_en_in(ext_en), .ext_val_in(ext_val), .level_out(pin));
   task automatic chk(string what, logic [40:0] exp, logic [40:0] got);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic wt(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic acc(logic w, logic [7:0] ad, logic [7:0] d);
      wt(1);
      wr = w;
      rd = ~w;
      addr = ad;
      wdat = d;
      wt(1);
      wr = 0;
      rd = 0;
   endtask
   task automatic rchk(logic [7:0] ad, logic [7:0] exp);
      acc(0, ad, 8'h00);
      chk("read data", exp, rdat);
      chk("hit", ad != 8'h27, hit);
   endtask
   task automatic t_reset();
      chk("pad drive", '1, pout);
      chk("pad enable", '0, poe);
      chk("pull", '0, pull);
      for (int p = 0; p < 6; p++) begin
         rchk(8'h20 + 8'(4 * p), 8'(ext_val >> (8 * p)));
         rchk(8'h21 + 8'(4 * p), p == 5 ? 8'h01 : 8'hff);
         rchk(8'h22 + 8'(4 * p), 8'h00);
      end
      rchk(8'h23, 8'h00);
      rchk(8'h27, 8'h00);
   endtask
   task automatic t_out();
      acc(1, 8'h24, 8'h5a);
      acc(1, 8'h25, 8'h0f);
      wt(1);
      chk("port b enable", 8'hf0, poe.pb);
      ext_val.pb = 8'h33;
      rchk(8'h24, 8'h53);
      ext_val.pb = 8'hcc;
      rchk(8'h24, 8'h5c);
      chk("port b latch", 8'h5a, pout.pb);
   endtask
   task automatic t_pull();
      ext_en.pc = 8'h00;
      acc(1, 8'h28, 8'h00);
      acc(1, 8'h29, 8'hf0);
      acc(1, 8'h2a, 8'hff);
      rchk(8'h2a, 8'hff);
      chk("port c pull", 8'hf0, pull.pc);
      rchk(8'h28, 8'hf0);
      acc(1, 8'h2a, 8'h00);
      wt(1);
      chk("port c pull off", 8'h00, pull.pc);
   endtask
   task automatic t_pf();
      acc(1, 8'h36, 8'hff);
      rchk(8'h36, 8'h01);
      acc(1, 8'h34, 8'hfe);
      acc(1, 8'h35, 8'hfe);
      rchk(8'h35, 8'h00);
      rchk(8'h34, 8'h00);
      chk("port f enable", 1'b1, poe.pf);
   endtask
   task automatic t_wake();
      ext_val.pa = 8'hff;
      acc(1, 8'h20, 8'h3c);
      acc(1, 8'h21, 8'hff);
      acc(1, 8'h23, 8'h08);
      rchk(8'h23, 8'h08);
      ext_val.pa = 8'hf7;
      wt(6);
      slp = 1;
      wt(6);
      chk("wake after awake fall", 1'b0, wake);
      ext_val.pa = 8'hff;
      wt(6);
      ext_val.pa = 8'hfb;
      wt(8);
      chk("wake from masked pin", 1'b0, wake);
      ext_val.pa = 8'hf3;
      wt(6);
      chk("wake on fall", 1'b1, wake);
      slp = 0;
      wt(1);
      chk("wake after exit", 1'b0, wake);
   endtask
   task automatic test_done();
      $display("checks %0d, miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Ceiling well above the some 125 cycles the scenarios take
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         miscompares++;
         test_done();
      end
   end
   initial begin
      wt(10);
      rst = 0;
      t_reset();
      t_out();
      t_pull();
      t_pf();
      t_wake();
      test_done();
   end
endmodule
bind gpioph_top gpioph_monitor #(.ADDR_W(ADDR_W)) i_mon (.*);
